// ### logic/adc_ser_pkg.sv
/*
  Shared constants for the serial result readout link: result width, timing
  counts at the 125 MHz system clock, and the controller's register map.
  Assumes both ends run on one 125 MHz clock and that the link pins are
  asynchronous to it.
*/
`default_nettype none

package adc_ser_pkg;

  // ***************************************************************
  // result and timing
  // ***************************************************************
  localparam int RESULT_W      = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS  = 10000;  // one conversion at 100 ksps
  localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int START_LOW_NS  = 40;
  localparam int START_LOW_CYC = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS  = 24;     // longest half period, keeps sclk above 18 MHz
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int LEAD_CYC      = 8;      // select-to-first-edge settle, covers both synchronisers

  // ***************************************************************
  // controller register map
  // ***************************************************************
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_MASK   = 4'h8;
  localparam logic [3:0]  OFS_DATA   = 4'hc;

  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_DURING_BIT = 1;
  localparam int CTRL_IDLE_HI_BIT = 2;
  localparam int CTRL_LEN_LSB    = 8;
  localparam int CTRL_LEN_W      = 6;
  localparam logic [CTRL_LEN_W-1:0] CTRL_LEN_RESET = 6'h10;

  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_W         = 2;
  localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;

endpackage

`default_nettype wire

// ### logic/adc_link_if.sv
/*
  Link between the converter's serial readout end and its host controller.
  Assumes the bench resolves the tri-state result line from serial_result_oe.
*/
`default_nettype none

interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic rd_n;
  logic convert_start_n;
  logic clock_source_select;
  logic port_type_select;
  logic read_mode_chain_in;
  logic serial_result_out;
  logic serial_result_oe;
  logic busy;
  logic read_fault_pulse;

  modport device (
    input  sclk, cs_n, rd_n, convert_start_n, clock_source_select,
    input  port_type_select, read_mode_chain_in,
    output serial_result_out, serial_result_oe, busy, read_fault_pulse
  );

  modport host (
    output sclk, cs_n, rd_n, convert_start_n, clock_source_select,
    output port_type_select, read_mode_chain_in,
    input  serial_result_out, serial_result_oe, busy, read_fault_pulse
  );
endinterface

`default_nettype wire

// ### logic/adc_serial_end.sv
/*
  Converter end of the serial readout link in external-clock (slave) mode:
  conversion timing, busy, result latch, result shifter with chain
  forwarding, and the read-fault pulse.
  Assumes all link pins are asynchronous to CLK; every one passes two
  flip-flops. SAMPLE_DATA stands for the conversion engine's output.
*/
`default_nettype none

module adc_serial_end
  import adc_ser_pkg::*;
#(
  parameter int CONV_CYC_P = CONV_CYC
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_B,
  // link
  adc_link_if.device               LINK,
  // conversion engine side
  input  wire logic [RESULT_W-1:0] SAMPLE_DATA,
  input  wire logic                READ_DURING,
  output logic      [RESULT_W-1:0] RESULT,
  output logic                     NEW_RESULT
);

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  localparam int IN_W      = 8;
  localparam int I_SCLK    = 7;
  localparam int I_CS      = 6;
  localparam int I_RD      = 5;
  localparam int I_CNV     = 4;
  localparam int I_CHAIN   = 3;
  localparam int I_EXT     = 2;
  localparam int I_SER     = 1;
  localparam int I_DURING  = 0;
  localparam int CONV_W    = $clog2(CONV_CYC_P + 1);
  localparam int BITS_W    = $clog2(RESULT_W + 1);

  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] in_meta_q;
  logic [IN_W-1:0] in_sync_q;
  logic            sclk_prev_q;
  logic            cnv_prev_q;

  assign in_raw = {LINK.sclk, LINK.cs_n, LINK.rd_n, LINK.convert_start_n,
                   LINK.read_mode_chain_in, LINK.clock_source_select,
                   LINK.port_type_select, READ_DURING};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      // inactive levels: clock low, strobes and start high, so no false edge follows reset
      in_meta_q   <= 8'h70;
      in_sync_q   <= 8'h70;
      sclk_prev_q <= 1'b0;
      cnv_prev_q  <= 1'b1;
    end else begin
      in_meta_q   <= in_raw;
      in_sync_q   <= in_meta_q;
      sclk_prev_q <= in_sync_q[I_SCLK];
      cnv_prev_q  <= in_sync_q[I_CNV];
    end
  end

  // ***************************************************************
  // decode
  // ***************************************************************
  // edges are found on the sampled clock, so any idle level and any gap work
  wire sclk_rise   = in_sync_q[I_SCLK] & ~sclk_prev_q;
  wire sclk_fall   = ~in_sync_q[I_SCLK] & sclk_prev_q;
  wire cnv_fall    = ~in_sync_q[I_CNV] & cnv_prev_q;
  wire during_mode = in_sync_q[I_DURING];
  // only the slave serial port is built; internal-clock mode keeps the line off
  wire serial_on   = in_sync_q[I_EXT] & in_sync_q[I_SER];
  wire strobes_low = ~(in_sync_q[I_CS] | in_sync_q[I_RD]);

  // ***************************************************************
  // conversion timing
  // ***************************************************************
  logic                busy_q;
  logic [CONV_W-1:0]   conv_cnt_q;
  logic [RESULT_W-1:0] result_q;
  logic                new_result_q;

  wire conv_end   = busy_q & (conv_cnt_q == CONV_W'(CONV_CYC_P - 1));
  // a start edge while busy is ignored: a conversion cannot be restarted
  wire conv_start = cnv_fall & ~busy_q;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_q     <= 1'b0;
      conv_cnt_q <= '0;
    end else if (conv_start) begin
      busy_q     <= 1'b1;
      conv_cnt_q <= '0;
    end else if (conv_end) begin
      busy_q     <= 1'b0;
      conv_cnt_q <= '0;
    end else if (busy_q) begin
      conv_cnt_q <= conv_cnt_q + CONV_W'(1);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      result_q     <= '0;
      new_result_q <= 1'b0;
    end else begin
      new_result_q <= conv_end;
      if (conv_end) begin
        result_q <= SAMPLE_DATA;
      end
    end
  end

  // ***************************************************************
  // readout window and shifter
  // ***************************************************************
  // read-after opens once busy is low, read-during only while busy is high
  wire window_ok   = during_mode ? busy_q : ~busy_q;
  wire read_active = serial_on & strobes_low & window_ok;
  // during a conversion result_q still holds the previous result
  wire [RESULT_W-1:0] load_val = conv_end ? SAMPLE_DATA : result_q;
  wire chain_ok    = ~during_mode & in_sync_q[I_EXT];

  logic [RESULT_W-1:0] shift_q;
  logic                chain_q;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      shift_q <= '0;
    end else if (!read_active || conv_end) begin
      shift_q <= load_val;
    end else if (sclk_rise) begin
      // after the local lsb the captured chain bits follow one per clock
      shift_q <= {shift_q[RESULT_W-2:0], chain_q & chain_ok};
    end
  end

  // chain bit is taken on the falling edge, output moves on the rising one
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      chain_q <= 1'b0;
    end else if (read_active && sclk_fall) begin
      chain_q <= in_sync_q[I_CHAIN];
    end
  end

  // ***************************************************************
  // unfinished read detection
  // ***************************************************************
  logic [BITS_W-1:0] bits_q;
  logic              started_q;
  logic              complete_q;
  logic              fault_q;

  wire bits_full = (bits_q == BITS_W'(RESULT_W));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bits_q <= '0;
    end else if (!read_active || conv_end) begin
      bits_q <= '0;
    end else if (sclk_rise && !bits_full) begin
      bits_q <= bits_q + BITS_W'(1);
    end
  end

  // a read begun during conversion must see all bits before busy falls
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      started_q  <= 1'b0;
      complete_q <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      fault_q <= conv_end & during_mode & started_q & ~complete_q;
      if (conv_start || conv_end) begin
        started_q  <= 1'b0;
        complete_q <= 1'b0;
      end else begin
        if (read_active && during_mode) begin
          started_q <= 1'b1;
        end
        if (read_active && bits_full) begin
          complete_q <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // the 40 MHz ceiling is not reachable here: the clock is oversampled by CLK
  assign LINK.serial_result_out = shift_q[RESULT_W-1];
  assign LINK.serial_result_oe  = read_active;
  assign LINK.busy              = busy_q;
  assign LINK.read_fault_pulse  = fault_q;
  assign RESULT                 = result_q;
  assign NEW_RESULT             = new_result_q;

endmodule // adc_serial_end

`default_nettype wire

// ### logic/adc_serial_host.sv
/*
  Host end of the serial readout link: starts conversions, generates the
  serial clock by division, drives the strobes and collects the result
  into registers with a sticky status, mask and interrupt.
  Assumes a simple register port with read data one cycle after the strobe.
*/
`default_nettype none

module adc_serial_host
  import adc_ser_pkg::*;
#(
  parameter int START_P = START_LOW_CYC,
  parameter int HALF_P  = SCLK_HALF_CYC,
  parameter int LEAD_P  = LEAD_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // link
  adc_link_if.host         LINK,
  // register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             IRQ
);

  typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_WAIT_HI, ST_WAIT_LO, ST_LEAD, ST_SHIFT} st_e;

  // ***************************************************************
  // registers
  // ***************************************************************
  logic                  during_q;
  logic                  idle_hi_q;
  logic [CTRL_LEN_W-1:0] len_q;
  logic [STAT_W-1:0]     stat_q;
  logic [STAT_W-1:0]     mask_q;
  logic [31:0]           data_q;
  logic [31:0]           rdata_q;
  logic [2:0]            meta_q;
  logic [2:0]            sync_q;
  logic                  fault_prev_q;
  st_e                   st_q;
  logic [7:0]            tmr_q;
  logic [CTRL_LEN_W-1:0] cnt_q;
  logic                  sclk_q;
  logic                  sel_n_q;
  logic                  cnv_n_q;

  wire wr_ctrl  = WR & (ADDR == OFS_CTRL);
  wire wr_mask  = WR & (ADDR == OFS_MASK);
  wire rd_stat  = RD & (ADDR == OFS_STATUS);
  wire start    = wr_ctrl & WDATA[CTRL_START_BIT] & (st_q == ST_IDLE);
  wire busy_s   = sync_q[2];
  wire fault_s  = sync_q[1];
  wire sdo_s    = sync_q[0];
  wire tmr_zero = (tmr_q == 8'h00);
  wire sh_done  = (st_q == ST_SHIFT) & tmr_zero & (cnt_q == len_q) & (sclk_q == idle_hi_q);
  wire sh_rise  = (st_q == ST_SHIFT) & tmr_zero & ~sh_done & ~sclk_q;
  wire [STAT_W-1:0] events = {fault_s & ~fault_prev_q, sh_done};
  wire [31:0] rd_mux =
      (ADDR == OFS_CTRL)   ? {18'h0, len_q, 5'h0, idle_hi_q, during_q, 1'b0} :
      (ADDR == OFS_STATUS) ? {30'h0, stat_q} :
      (ADDR == OFS_MASK)   ? {30'h0, mask_q} :
      (ADDR == OFS_DATA)   ? data_q : 32'h0;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      during_q  <= 1'b0;
      idle_hi_q <= 1'b0;
      len_q     <= CTRL_LEN_RESET;
      mask_q    <= MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        during_q  <= WDATA[CTRL_DURING_BIT];
        idle_hi_q <= WDATA[CTRL_IDLE_HI_BIT];
        len_q     <= WDATA[CTRL_LEN_LSB +: CTRL_LEN_W];
      end
      if (wr_mask) begin
        mask_q <= WDATA[STAT_W-1:0];
      end
    end
  end

  // a status read clears, an event in the same cycle still sets
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_q  <= '0;
      rdata_q <= '0;
    end else begin
      stat_q  <= (stat_q & ~{STAT_W{rd_stat}}) | events;
      rdata_q <= RD ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_q       <= 3'h0;
      sync_q       <= 3'h0;
      fault_prev_q <= 1'b0;
    end else begin
      meta_q       <= {LINK.busy, LINK.read_fault_pulse, LINK.serial_result_out};
      sync_q       <= meta_q;
      fault_prev_q <= fault_s;
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q    <= ST_IDLE;
      tmr_q   <= 8'h00;
      cnt_q   <= '0;
      sclk_q  <= 1'b0;
      sel_n_q <= 1'b1;
      cnv_n_q <= 1'b1;
      data_q  <= '0;
    end else begin
      tmr_q <= tmr_zero ? 8'h00 : tmr_q - 8'h01;
      case (st_q)
        ST_IDLE: begin
          sclk_q <= idle_hi_q;
          if (start) begin
            st_q    <= ST_CONV;
            cnv_n_q <= 1'b0;
            tmr_q   <= 8'(START_P - 1);
          end
        end
        ST_CONV: begin
          if (tmr_zero) begin
            cnv_n_q <= 1'b1;
            st_q    <= ST_WAIT_HI;
          end
        end
        ST_WAIT_HI: begin
          if (busy_s) begin
            st_q <= during_q ? ST_LEAD : ST_WAIT_LO;
            // clocking only in the first part of busy in read-during mode
            sel_n_q <= ~during_q;
            tmr_q   <= 8'(LEAD_P - 1);
          end
        end
        ST_WAIT_LO: begin
          // read-after: clock stays quiet for the whole of busy
          if (!busy_s) begin
            st_q    <= ST_LEAD;
            sel_n_q <= 1'b0;
            tmr_q   <= 8'(LEAD_P - 1);
          end
        end
        ST_LEAD: begin
          cnt_q  <= '0;
          // only this transfer's bits are reported, nothing left from the last one
          data_q <= '0;
          if (tmr_zero) begin
            st_q  <= ST_SHIFT;
            tmr_q <= 8'(HALF_P - 1);
          end
        end
        ST_SHIFT: begin
          if (sh_done) begin
            st_q    <= ST_IDLE;
            sel_n_q <= 1'b1;
          end else if (tmr_zero) begin
            sclk_q <= ~sclk_q;
            tmr_q  <= 8'(HALF_P - 1);
            if (sh_rise) begin
              data_q <= {data_q[30:0], sdo_s};
              cnt_q  <= cnt_q + CTRL_LEN_W'(1);
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign LINK.sclk                = sclk_q;
  assign LINK.cs_n                = sel_n_q;
  assign LINK.rd_n                = sel_n_q;
  assign LINK.convert_start_n     = cnv_n_q;
  assign LINK.clock_source_select = 1'b1;
  assign LINK.port_type_select    = 1'b1;
  // no chain upstream of a lone converter: the pin is held at a fixed level
  assign LINK.read_mode_chain_in  = 1'b0;
  assign RDATA                    = rdata_q;
  assign IRQ                      = |(stat_q & mask_q);

endmodule // adc_serial_host

`default_nettype wire

// ### dv/adc_ser_props.sv
/*
  Timing checks on the readout link between the host end and the converter end.
  Assumes one clock domain and the link signals wired in by name beside the interface.
*/
`default_nettype none

module adc_ser_props #(
  parameter int CONV_CYC_P = 400
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic convert_start_n,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic busy,
  input wire logic read_fault_pulse
);
  // ***************************************************************
  // cycle counters
  // ***************************************************************
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  logic [7:0]  low_cnt_q;
  logic [7:0]  low_cnt_d;
  logic [7:0]  rise_cnt_q;
  logic [7:0]  rise_cnt_d;
  logic        sclk_q;

  // low and rise counters saturate, so a long idle never wraps back into a short window
  assign busy_cnt_d = busy ? busy_cnt_q + 16'h1 : 16'h0;
  assign low_cnt_d  = busy ? 8'h0 : low_cnt_q + 8'(low_cnt_q != 8'hff);
  assign rise_cnt_d = (sclk && !sclk_q) ? 8'h0 : rise_cnt_q + 8'(rise_cnt_q != 8'hff);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cnt_q <= 16'h0;
      low_cnt_q  <= 8'hff;
      rise_cnt_q <= 8'hff;
      sclk_q     <= 1'b0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
      low_cnt_q  <= low_cnt_d;
      rise_cnt_q <= rise_cnt_d;
      sclk_q     <= sclk;
    end
  end

  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence start_fell;
    $fell(convert_start_n) ##0 !busy;
  endsequence
  sequence strobes_off;
    (cs_n || rd_n) [*3];
  endsequence

  a_busy_after_start: assert property (start_fell |-> ##[2:4] busy)
    else $error("busy missing after start");
  a_busy_has_cause: assert property ($rose(busy) |-> !$past(convert_start_n, 2))
    else $error("busy rose without start");
  a_busy_length: assert property ($fell(busy) |->
    busy_cnt_q >= 16'(CONV_CYC_P - 4) && busy_cnt_q <= 16'(CONV_CYC_P + 4))
    else $error("busy length wrong");
  a_fault_single: assert property (read_fault_pulse |=> !read_fault_pulse)
    else $error("fault pulse too long");
  a_fault_at_end: assert property (read_fault_pulse |->
    (busy ? busy_cnt_q >= 16'(CONV_CYC_P - 6) : low_cnt_q <= 8'h6))
    else $error("fault away from conversion end");
  a_off_when_free: assert property (strobes_off |-> !serial_result_oe)
    else $error("output driven while deselected");
  a_data_after_rise: assert property ($changed(serial_result_out) && serial_result_oe &&
    $past(serial_result_oe) |-> rise_cnt_q >= 8'h1 && rise_cnt_q <= 8'h6)
    else $error("data moved away from clock rise");
  a_sclk_quiet_late: assert property ($changed(sclk) |->
    !busy || busy_cnt_q < 16'(CONV_CYC_P / 2))
    else $error("clock moved in late conversion");
endmodule // adc_ser_props

`default_nettype wire

// ### dv/adc_slave_serial_readout_tb_top.sv
/*
  Self-checking bench: host end and converter end joined by the link interface,
  driven through the host's register port, with the link checker alongside.
  Assumes the package constants and link interface as delivered.
*/
`default_nettype none

module adc_slave_serial_readout_tb_top
  import adc_ser_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // shortened conversion keeps a read-during transfer inside its first half
  localparam int CONV_P = 400;
  localparam int LIMIT  = 60000;

  logic                clk;
  logic                rst_b;
  logic [3:0]          addr;
  logic [31:0]         wdata;
  logic                wr;
  logic                rd;
  logic [31:0]         rdata;
  logic                irq;
  logic [RESULT_W-1:0] sample_data;
  logic                read_during;
  logic [RESULT_W-1:0] result;
  logic [15:0]         lfsr_q;
  logic [15:0]         last_res;
  logic [1:0]          mask;
  logic [15:0]         corner [4] = '{16'h0000, 16'hffff, 16'h8001, 16'h7ffe};
  int                  num_errors = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  logic                new_result;
  int                  num_results = 0;

  adc_link_if u_adc_link_if ();
  adc_serial_end #(.CONV_CYC_P(CONV_P)) u_adc_serial_end (
    .CLK(clk), .RST_B(rst_b), .LINK(u_adc_link_if.device), .SAMPLE_DATA(sample_data),
    .READ_DURING(read_during), .RESULT(result), .NEW_RESULT(new_result));
  adc_serial_host #(.HALF_P(4)) u_adc_serial_host (
    .CLK(clk), .RST_B(rst_b), .LINK(u_adc_link_if.host), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
  adc_ser_props #(.CONV_CYC_P(CONV_P)) u_adc_ser_props (
    .CLK(clk), .RST_B(rst_b), .sclk(u_adc_link_if.sclk), .cs_n(u_adc_link_if.cs_n),
    .rd_n(u_adc_link_if.rd_n), .convert_start_n(u_adc_link_if.convert_start_n),
    .serial_result_out(u_adc_link_if.serial_result_out),
    .serial_result_oe(u_adc_link_if.serial_result_oe), .busy(u_adc_link_if.busy),
    .read_fault_pulse(u_adc_link_if.read_fault_pulse));

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // local bits first, then zeros forwarded from the idle chain input
  function automatic logic [31:0] exp_data(input logic [15:0] v, input int len);
    logic [47:0] w;
    w = {v, 32'h0};
    return 32'(w >> (48 - len));
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // one conversion and readout, then data, status and interrupt checks
  task automatic xfer(input logic dur, input logic idle, input int len, input logic [15:0] smp);
    logic [31:0] d;
    logic [31:0] c;
    logic [1:0]  st;
    int          n;
    int          r0;
    st = {dur && len < 16, 1'b1};
    c = (32'(len) << CTRL_LEN_LSB) | (32'(idle) << CTRL_IDLE_HI_BIT) |
        (32'(dur) << CTRL_DURING_BIT) | 32'h1;
    sample_data <= smp;
    read_during <= dur;
    repeat (4) @(posedge clk);
    r0 = num_results;
    reg_wr(OFS_CTRL, c);
    n = 0;
    while ((irq !== 1'b1 && n < 1200) || (u_adc_link_if.busy !== 1'b0 && n < 2400)) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    cmp_bit("irq", |(st & mask), irq);
    reg_rd(OFS_DATA, d);
    cmp_word("data", exp_data(dur ? last_res : smp, len), d);
    reg_rd(OFS_STATUS, d);
    cmp_word("status", 32'(st), d);
    cmp_bit("irq after clear", 1'b0, irq);
    cmp_word("result", 32'(smp), 32'(result));
    cmp_word("new result", 32'(r0 + 1), 32'(num_results));
    last_res = smp;
  endtask

  // ***************************************************************
  // clock, timeout and sequence
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // one pulse per finished conversion
  always @(posedge clk) begin
    if (new_result === 1'b1) begin
      num_results++;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    logic [31:0] d;
    rst_b = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    sample_data = 16'h0;
    read_during = 1'b0;
    mask = 2'h0;
    last_res = 16'h0;
    lfsr_q = 16'h7;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(OFS_CTRL, d);
    cmp_word("ctrl reset", 32'(CTRL_LEN_RESET) << CTRL_LEN_LSB, d);
    reg_rd(OFS_MASK, d);
    cmp_word("mask reset", 32'(MASK_RESET), d);
    reg_wr(4'h2, 32'hffff_ffff);
    reg_rd(4'h2, d);
    cmp_word("unmapped", 32'h0, d);
    cmp_bit("irq reset", 1'b0, irq);
    reg_wr(OFS_MASK, 32'h3);
    mask = 2'h3;
    reg_rd(OFS_MASK, d);
    cmp_word("mask", 32'h3, d);
    foreach (corner[i]) xfer(1'b0, i[0], 16, corner[i]);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      xfer(1'b0, lfsr_q[0], 16, lfsr_q);
    end
    xfer(1'b0, 1'b0, 20, 16'ha5c3);
    xfer(1'b0, 1'b1, 32, 16'h3c5a);
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      xfer(1'b1, lfsr_q[1], 16, lfsr_q);
    end
    xfer(1'b1, 1'b0, 8, 16'h1234);
    reg_wr(OFS_MASK, 32'h2);
    mask = 2'h2;
    xfer(1'b0, 1'b0, 16, 16'hc001);
    xfer(1'b1, 1'b1, 4, 16'h0f0f);
    close_out();
  end
endmodule // adc_slave_serial_readout_tb_top

`default_nettype wire
